// >>> include/irqb_pkg.sv
// Constants, register map and source tables of the interrupt enable and priority bank
package irqb_pkg;

   // ********************************************************************
   // Register map
   // ********************************************************************
   localparam logic [7:0] IRQB_ADDR_EN_EXTRA  = 8'ha7;
   localparam logic [7:0] IRQB_ADDR_EN_MAIN   = 8'ha8;
   localparam logic [7:0] IRQB_ADDR_LVL_EXTRA = 8'hb7;
   localparam logic [7:0] IRQB_ADDR_LVL_MAIN  = 8'hb8;
   localparam logic [7:0] IRQB_REG_RESET      = 8'h00;
   localparam logic [7:0] IRQB_RDATA_NONE     = 8'h00;

   // Bits that hold state; the rest read as zero
   localparam logic [7:0] IRQB_MASK_EN_MAIN   = 8'hff;
   localparam logic [7:0] IRQB_MASK_EN_EXTRA  = 8'hf2;
   localparam logic [7:0] IRQB_MASK_LVL_MAIN  = 8'h3f;
   localparam logic [7:0] IRQB_MASK_LVL_EXTRA = 8'hf2;

   // ********************************************************************
   // Field positions
   // ********************************************************************
   localparam int IRQB_B_GATE  = 7;
   localparam int IRQB_B_TRACE = 6;
   localparam int IRQB_B_T2    = 5;
   localparam int IRQB_B_U0    = 4;
   localparam int IRQB_B_T1    = 3;
   localparam int IRQB_B_X1    = 2;
   localparam int IRQB_B_T0    = 1;
   localparam int IRQB_B_X0    = 0;
   localparam int IRQB_B_ADC   = 7;
   localparam int IRQB_B_SPI   = 6;
   localparam int IRQB_B_PCA   = 5;
   localparam int IRQB_B_U1    = 4;
   localparam int IRQB_B_I2C   = 1;

   // ********************************************************************
   // Sources, indexed in polling order (0 is polled first)
   // ********************************************************************
   localparam int IRQB_NSRC      = 11;
   localparam int IRQB_IDX_W     = 4;
   localparam int IRQB_SRC_EXT0  = 0;
   localparam int IRQB_SRC_TMR0  = 1;
   localparam int IRQB_SRC_EXT1  = 2;
   localparam int IRQB_SRC_TMR1  = 3;
   localparam int IRQB_SRC_UART0 = 4;
   localparam int IRQB_SRC_TMR2  = 5;
   localparam int IRQB_SRC_SPI   = 6;
   localparam int IRQB_SRC_I2C   = 7;
   localparam int IRQB_SRC_ADC   = 8;
   localparam int IRQB_SRC_ARRAY = 9;
   localparam int IRQB_SRC_UART1 = 10;

   localparam logic [15:0] IRQB_VEC_TABLE [IRQB_NSRC] = '{
      16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b,
      16'h0053, 16'h0043, 16'h003b, 16'h005b, 16'h004b};
   localparam logic [15:0] IRQB_VEC_NONE = 16'h0000;

   // ********************************************************************
   // Counter array flags
   // ********************************************************************
   localparam int IRQB_NUM_MATCH = 6;
   localparam int IRQB_NUM_WRAP  = 2;
   localparam int IRQB_NUM_ARRAY = IRQB_NUM_MATCH + IRQB_NUM_WRAP;

endpackage

// >>> hw/irqb_pin_sync.sv
// Three-stage synchroniser with agreement filter for one external pin
`timescale 1ns/1ps
module irqb_pin_sync #(
   parameter logic RESET_VAL = 1'b1
) (
   input  wire logic mclk,     // Core clock
   input  wire logic reset_n,  // Asynchronous reset
   input  wire logic pin_in,   // Raw pin level
   output logic      pin_val   // Filtered level
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic val;
   } irqb_sync_t;

   irqb_sync_t st_r;
   irqb_sync_t st_nxt;

   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = pin_in;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      // Change accepted only once stages two and three agree
      if (st_r.s2 == st_r.s3) begin
         st_nxt.val = st_r.s3;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= {4{RESET_VAL}};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pin_val = st_r.val;

endmodule

// >>> hw/irqb_poll_pick.sv
// Fixed polling-order picker: lowest candidate index wins
`timescale 1ns/1ps
module irqb_poll_pick #(
   parameter int N     = 11,
   parameter int IDX_W = 4
) (
   input  wire logic [N-1:0]     cand,        // Eligible requests
   output logic                  pick_valid,  // Any candidate present
   output logic [IDX_W-1:0]      pick_idx     // Winning index
);

   always_comb begin
      pick_valid = 1'b0;
      pick_idx   = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (cand[i]) begin
            pick_valid = 1'b1;
            pick_idx   = IDX_W'(i);
         end
      end
   end

endmodule

// >>> hw/irqb_bank.sv
// Interrupt enable, priority and request bank facing the processor core
`timescale 1ns/1ps

// Overview of operation
// - Conversion done sets converter flag
// - Eight array flags ORed into one request
// - Six module match flags, five to zero
// - Two counter wrap flags, one per counter
// - Global gate off blocks all requests
// - Main enable bits five..zero per source
// - Extra enable bits: converter, SPI, array, UART1, I2C
// - Main level bits choose high or low
// - Extra level bits choose high or low
// - All four registers reset to zero
// - Edge pending cleared on entry, level not
module irqb_bank
   import irqb_pkg::*;
(
   input  wire logic                        mclk,               // Core clock
   input  wire logic                        reset_n,            // Asynchronous reset, active low
   input  wire logic [7:0]                  sfr_addr,           // Register address
   input  wire logic                        sfr_wr,             // Register write strobe
   input  wire logic [7:0]                  sfr_wdata,          // Register write data
   input  wire logic                        sfr_rd,             // Register read strobe
   output logic [7:0]                       sfr_rdata,          // Register read data, one cycle later
   input  wire logic                        ext0_pin_n,         // External request pin 0, active low
   input  wire logic                        ext1_pin_n,         // External request pin 1, active low
   input  wire logic                        ext0_edge_mode,     // 1 falling edge, 0 low level
   input  wire logic                        ext1_edge_mode,     // 1 falling edge, 0 low level
   input  wire logic                        timer0_req,         // Timer 0 overflow flag
   input  wire logic                        timer1_req,         // Timer 1 overflow flag
   input  wire logic                        timer2_req,         // Timer 2 combined flag
   input  wire logic                        uart0_req,          // UART0 combined flag
   input  wire logic                        uart1_req,          // UART1 combined flag
   input  wire logic                        spi_req,            // SPI combined flag
   input  wire logic                        i2c_req,            // I2C flag
   input  wire logic                        conv_done,          // Conversion finished pulse
   input  wire logic                        conv_flag_clr,      // Software clears converter flag
   input  wire logic [IRQB_NUM_MATCH-1:0]   module_match_evt,   // Match or capture pulse per module
   input  wire logic [IRQB_NUM_WRAP-1:0]    counter_wrap_evt,   // Wrap pulse, bit 1 counter 1
   input  wire logic [IRQB_NUM_ARRAY-1:0]   array_flag_clr,     // Software clears array flags
   input  wire logic                        irq_ack,            // Core enters service routine
   input  wire logic                        irq_reti,           // Core returns from service routine
   output logic                             irq_req,            // Request to core
   output logic [15:0]                      irq_vector,         // Vector of requested source
   output logic [IRQB_IDX_W-1:0]            irq_src,            // Requested source index
   output logic                             irq_high,           // Requested source is high level
   output logic                             ext0_pending,       // External 0 pending flag
   output logic                             ext1_pending,       // External 1 pending flag
   output logic                             converter_done_flag,// Converter flag
   output logic [IRQB_NUM_MATCH-1:0]        module_match_flags, // Match or capture flags
   output logic                             counter1_wrap_flag, // Counter 1 wrap flag
   output logic                             counter0_wrap_flag, // Counter 0 wrap flag
   output logic                             array_irq           // Combined array request
);

   // ********************************************************************
   // State
   // ********************************************************************
   typedef struct packed {
      logic [7:0]                  en_main;
      logic [7:0]                  en_extra;
      logic [7:0]                  lvl_main;
      logic [7:0]                  lvl_extra;
      logic                        x0_pend;
      logic                        x1_pend;
      logic                        x0_prev;
      logic                        x1_prev;
      logic                        conv_flag;
      logic [IRQB_NUM_ARRAY-1:0]   array_flags;
      logic                        array_irq;
      logic                        in_hi;
      logic                        in_lo;
      logic                        req;
      logic                        high;
      logic [IRQB_IDX_W-1:0]       src;
      logic [15:0]                 vector;
      logic [7:0]                  rdata;
   } irqb_state_t;

   irqb_state_t st_r;
   irqb_state_t st_nxt;

   logic                        x0_lvl;
   logic                        x1_lvl;
   logic [IRQB_NSRC-1:0]        src_pend;
   logic [IRQB_NSRC-1:0]        src_en;
   logic [IRQB_NSRC-1:0]        src_lvl;
   logic [IRQB_NSRC-1:0]        cand;
   logic                        pick_valid;
   logic [IRQB_IDX_W-1:0]       pick_idx;
   logic                        gate_on;
   logic                        in_hi_n;
   logic                        in_lo_n;

   // ********************************************************************
   // Pin synchronisers
   // ********************************************************************
   irqb_pin_sync #(
      .RESET_VAL (1'b1)
   ) u_sync_x0 (
      .mclk    (mclk),
      .reset_n (reset_n),
      .pin_in  (ext0_pin_n),
      .pin_val (x0_lvl)
   );

   irqb_pin_sync #(
      .RESET_VAL (1'b1)
   ) u_sync_x1 (
      .mclk    (mclk),
      .reset_n (reset_n),
      .pin_in  (ext1_pin_n),
      .pin_val (x1_lvl)
   );

   // ********************************************************************
   // Source vectors in polling order
   // ********************************************************************
   assign src_en = {st_nxt.en_extra[IRQB_B_U1], st_nxt.en_extra[IRQB_B_PCA],
                    st_nxt.en_extra[IRQB_B_ADC], st_nxt.en_extra[IRQB_B_I2C],
                    st_nxt.en_extra[IRQB_B_SPI], st_nxt.en_main[IRQB_B_T2],
                    st_nxt.en_main[IRQB_B_U0], st_nxt.en_main[IRQB_B_T1],
                    st_nxt.en_main[IRQB_B_X1], st_nxt.en_main[IRQB_B_T0],
                    st_nxt.en_main[IRQB_B_X0]};
   assign src_lvl = {st_nxt.lvl_extra[IRQB_B_U1], st_nxt.lvl_extra[IRQB_B_PCA],
                     st_nxt.lvl_extra[IRQB_B_ADC], st_nxt.lvl_extra[IRQB_B_I2C],
                     st_nxt.lvl_extra[IRQB_B_SPI], st_nxt.lvl_main[IRQB_B_T2],
                     st_nxt.lvl_main[IRQB_B_U0], st_nxt.lvl_main[IRQB_B_T1],
                     st_nxt.lvl_main[IRQB_B_X1], st_nxt.lvl_main[IRQB_B_T0],
                     st_nxt.lvl_main[IRQB_B_X0]};
   assign src_pend = {uart1_req, st_nxt.array_irq, st_nxt.conv_flag, i2c_req, spi_req,
                      timer2_req, uart0_req, timer1_req, st_nxt.x1_pend, timer0_req,
                      st_nxt.x0_pend};
   assign gate_on = st_nxt.en_main[IRQB_B_GATE];

   // High may preempt low only; nothing preempts a high routine
   genvar gi;
   generate
      for (gi = 0; gi < IRQB_NSRC; gi++) begin : g_cand
         assign cand[gi] = gate_on & src_en[gi] & src_pend[gi] & !in_hi_n &
                           (src_lvl[gi] | (!in_lo_n & !(|(src_lvl & src_en & src_pend))));
      end
   endgenerate

   irqb_poll_pick #(
      .N     (IRQB_NSRC),
      .IDX_W (IRQB_IDX_W)
   ) u_pick (
      .cand       (cand),
      .pick_valid (pick_valid),
      .pick_idx   (pick_idx)
   );

   // ********************************************************************
   // Next state
   // ********************************************************************
   always_comb begin
      logic entry_x0;
      logic entry_x1;
      entry_x0 = 1'b0;
      entry_x1 = 1'b0;
      st_nxt   = st_r;
      in_hi_n  = st_r.in_hi;
      in_lo_n  = st_r.in_lo;

      // Register writes
      if (sfr_wr) begin
         case (sfr_addr)
            IRQB_ADDR_EN_MAIN:   st_nxt.en_main   = sfr_wdata & IRQB_MASK_EN_MAIN;
            IRQB_ADDR_EN_EXTRA:  st_nxt.en_extra  = sfr_wdata & IRQB_MASK_EN_EXTRA;
            IRQB_ADDR_LVL_MAIN:  st_nxt.lvl_main  = sfr_wdata & IRQB_MASK_LVL_MAIN;
            IRQB_ADDR_LVL_EXTRA: st_nxt.lvl_extra = sfr_wdata & IRQB_MASK_LVL_EXTRA;
            default: ;
         endcase
      end

      // Register reads, unmapped addresses return zero
      if (sfr_rd) begin
         case (sfr_addr)
            IRQB_ADDR_EN_MAIN:   st_nxt.rdata = st_r.en_main;
            IRQB_ADDR_EN_EXTRA:  st_nxt.rdata = st_r.en_extra;
            IRQB_ADDR_LVL_MAIN:  st_nxt.rdata = st_r.lvl_main;
            IRQB_ADDR_LVL_EXTRA: st_nxt.rdata = st_r.lvl_extra;
            default:             st_nxt.rdata = IRQB_RDATA_NONE;
         endcase
      end

      // Service nesting: return first, then entry
      if (irq_reti) begin
         if (in_hi_n) begin
            in_hi_n = 1'b0;
         end else begin
            in_lo_n = 1'b0;
         end
      end
      if (irq_ack && st_r.req) begin
         if (st_r.high) begin
            in_hi_n = 1'b1;
         end else begin
            in_lo_n = 1'b1;
         end
         entry_x0 = (st_r.src == IRQB_IDX_W'(IRQB_SRC_EXT0));
         entry_x1 = (st_r.src == IRQB_IDX_W'(IRQB_SRC_EXT1));
      end
      st_nxt.in_hi = in_hi_n;
      st_nxt.in_lo = in_lo_n;

      // External pending flags; a new edge beats the entry clear
      st_nxt.x0_prev = x0_lvl;
      st_nxt.x1_prev = x1_lvl;
      if (ext0_edge_mode) begin
         st_nxt.x0_pend = (st_r.x0_pend & !entry_x0) | (st_r.x0_prev & !x0_lvl);
      end else begin
         st_nxt.x0_pend = !x0_lvl;
      end
      if (ext1_edge_mode) begin
         st_nxt.x1_pend = (st_r.x1_pend & !entry_x1) | (st_r.x1_prev & !x1_lvl);
      end else begin
         st_nxt.x1_pend = !x1_lvl;
      end

      // Sticky converter and array flags, only software clears them
      st_nxt.conv_flag   = (st_r.conv_flag & !conv_flag_clr) | conv_done;
      st_nxt.array_flags = (st_r.array_flags & ~array_flag_clr) |
                           {counter_wrap_evt, module_match_evt};
      st_nxt.array_irq   = |st_nxt.array_flags;

      // Request toward the core
      st_nxt.req    = pick_valid;
      st_nxt.src    = pick_idx;
      st_nxt.high   = pick_valid & src_lvl[pick_idx];
      st_nxt.vector = pick_valid ? IRQB_VEC_TABLE[pick_idx] : IRQB_VEC_NONE;
   end

   // ********************************************************************
   // State register
   // ********************************************************************
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st_r           <= '0;
         st_r.en_main   <= IRQB_REG_RESET;
         st_r.en_extra  <= IRQB_REG_RESET;
         st_r.lvl_main  <= IRQB_REG_RESET;
         st_r.lvl_extra <= IRQB_REG_RESET;
         st_r.x0_prev   <= 1'b1;
         st_r.x1_prev   <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ********************************************************************
   // Outputs
   // ********************************************************************
   assign sfr_rdata           = st_r.rdata;
   assign irq_req             = st_r.req;
   assign irq_vector          = st_r.vector;
   assign irq_src             = st_r.src;
   assign irq_high            = st_r.high;
   assign ext0_pending        = st_r.x0_pend;
   assign ext1_pending        = st_r.x1_pend;
   assign converter_done_flag = st_r.conv_flag;
   assign module_match_flags  = st_r.array_flags[IRQB_NUM_MATCH-1:0];
   assign counter1_wrap_flag  = st_r.array_flags[IRQB_NUM_ARRAY-1];
   assign counter0_wrap_flag  = st_r.array_flags[IRQB_NUM_MATCH];
   assign array_irq           = st_r.array_irq;

endmodule

// >>> sim/irqb_core_model.sv
// Behavioural processor core that enters and leaves interrupt routines
`timescale 1ns/1ps
module irqb_core_model #(
   parameter int SVC = 20
) (
   input  wire logic       mclk,     // Core clock
   input  wire logic       reset_n,  // Asynchronous reset, active low
   input  wire logic       core_on,  // Accept new requests
   input  wire logic [3:0] ack_dly,  // Cycles before entry
   input  wire logic       irq_req,  // Request from bank
   output logic            irq_ack,  // Routine entry pulse
   output logic            irq_reti  // Routine return pulse
);
   // ********************************************************************
   // Routine entry, optional nesting, return
   // ********************************************************************
   task automatic serve(input int depth);
      int n;
      n = 0;
      irq_ack <= 1'b1;
      @(posedge mclk);
      irq_ack <= 1'b0;
      while (n < SVC) begin
         @(posedge mclk);
         if (irq_req && depth == 0 && n > 2) begin
            serve(1);
         end
         n++;
      end
      irq_reti <= 1'b1;
      @(posedge mclk);
      irq_reti <= 1'b0;
   endtask

   initial begin
      irq_ack = 1'b0;
      irq_reti = 1'b0;
      forever begin
         @(posedge mclk);
         if (reset_n && core_on && irq_req) begin
            repeat (ack_dly) @(posedge mclk);
            if (irq_req) begin
               serve(0);
            end
         end
      end
   end
endmodule

// >>> sim/irqb_bank_assertions.sv
// Concurrent checks on the interrupt bank ports
`timescale 1ns/1ps
module irqb_bank_assertions
   import irqb_pkg::*;
(
   input wire logic       mclk,                // Core clock
   input wire logic       reset_n,             // Reset, active low
   input wire logic [7:0] sfr_addr,            // Register address
   input wire logic       sfr_wr,              // Write strobe
   input wire logic [7:0] sfr_wdata,           // Write data
   input wire logic       sfr_rd,              // Read strobe
   input wire logic [7:0] sfr_rdata,           // Read data
   input wire logic       ext0_pin_n,          // External pin 0
   input wire logic       ext0_edge_mode,      // Edge mode 0
   input wire logic       conv_done,           // Conversion done
   input wire logic       conv_flag_clr,       // Converter clear
   input wire logic [5:0] module_match_evt,    // Match events
   input wire logic [1:0] counter_wrap_evt,    // Wrap events
   input wire logic       irq_ack,             // Entry
   input wire logic       irq_req,             // Request
   input wire logic [3:0] irq_src,             // Source index
   input wire logic       irq_high,            // High level
   input wire logic       ext0_pending,        // Pending 0
   input wire logic       converter_done_flag, // Converter flag
   input wire logic [5:0] module_match_flags,  // Match flags
   input wire logic       counter1_wrap_flag,  // Wrap flag 1
   input wire logic       counter0_wrap_flag,  // Wrap flag 0
   input wire logic       array_irq            // Array request
);
   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   // ********************************************************************
   // Entry sequences
   // ********************************************************************
   sequence s_high_entry;
      irq_req && irq_ack && irq_high;
   endsequence
   sequence s_ext0_entry;
      irq_req && irq_ack && irq_src == 4'h0;
   endsequence

   AST_CONV_SET: assert property (conv_done |=> converter_done_flag)
      else $error("converter flag not set");
   AST_ARRAY_OR: assert property (array_irq == |{counter1_wrap_flag, counter0_wrap_flag, module_match_flags})
      else $error("array request differs from flag OR");
   AST_MATCH_SET: assert property (|module_match_evt |=>
      (module_match_flags & $past(module_match_evt)) == $past(module_match_evt))
      else $error("match flag not set");
   AST_WRAP_SET: assert property (|counter_wrap_evt |=>
      ({counter1_wrap_flag, counter0_wrap_flag} & $past(counter_wrap_evt)) == $past(counter_wrap_evt))
      else $error("wrap flag not set");
   AST_GATE_OFF: assert property (sfr_wr && sfr_addr == IRQB_ADDR_EN_MAIN && !sfr_wdata[7] |-> ##2 !irq_req)
      else $error("request with gate off");
   AST_HIGH_BLOCK: assert property (s_high_entry |-> ##2 !irq_req)
      else $error("request during high routine");
   AST_EDGE_CLR: assert property (s_ext0_entry ##0 ext0_edge_mode |-> ##2 !ext0_pending)
      else $error("edge pending not cleared");
   AST_LEVEL_HOLD: assert property (s_ext0_entry ##0 !ext0_edge_mode && !ext0_pin_n |=> ext0_pending)
      else $error("level pending cleared");
   AST_CONV_STICKY: assert property (converter_done_flag && !conv_flag_clr |=> converter_done_flag)
      else $error("converter flag lost");
   AST_LVL_RSV: assert property (sfr_rd && sfr_addr == IRQB_ADDR_LVL_MAIN |=> sfr_rdata[7:6] == 2'b00)
      else $error("reserved level bits read nonzero");
   AST_EXTRA_RSV: assert property (sfr_rd && sfr_addr[3:0] == 4'h7 |=> (sfr_rdata & 8'h0d) == 8'h00)
      else $error("reserved extra bits read nonzero");
endmodule

bind irqb_bank irqb_bank_assertions chk_u (.*);

// >>> sim/tb_irqb_bank.sv
// Self-checking testbench of the interrupt bank
`timescale 1ns/1ps
module tb_irqb_bank;
   import irqb_pkg::*;
   logic mclk, reset_n, sfr_wr, sfr_rd, ext0_pin_n, ext1_pin_n, ext0_edge_mode, ext1_edge_mode;
   logic timer0_req, timer1_req, timer2_req, uart0_req, uart1_req, spi_req, i2c_req;
   logic conv_done, conv_flag_clr, irq_ack, irq_reti, irq_req, irq_high, ext0_pending, ext1_pending;
   logic converter_done_flag, counter1_wrap_flag, counter0_wrap_flag, array_irq, core_on, hit;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, array_flag_clr, v;
   logic [5:0] module_match_evt, module_match_flags;
   logic [1:0] counter_wrap_evt;
   logic [15:0] irq_vector;
   logic [3:0] irq_src, ack_dly;
   int errors, samples_checked;
   localparam logic [7:0] EMASK [11] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h02, 8'h80, 8'h20, 8'h10};
   localparam logic [7:0] RADDR [4] = '{IRQB_ADDR_EN_EXTRA, IRQB_ADDR_EN_MAIN, IRQB_ADDR_LVL_EXTRA, IRQB_ADDR_LVL_MAIN};
   localparam logic [7:0] RMASK [4] = '{8'hf2, 8'hbf, 8'hf2, 8'h3f};

   irqb_bank dut_u (.*);
   irqb_core_model core_u (.*);

   // ********************************************************************
   // Access tasks
   // ********************************************************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      if (errors == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      sfr_wr <= 1'b1;
      sfr_addr <= a;
      sfr_wdata <= d;
      @(posedge mclk);
      sfr_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      sfr_rd <= 1'b1;
      sfr_addr <= a;
      @(posedge mclk);
      sfr_rd <= 1'b0;
      #1 d = sfr_rdata;
   endtask
   task automatic en_main(input logic [7:0] d);
      logic [7:0] cur;
      rd(IRQB_ADDR_EN_MAIN, cur);
      wr(IRQB_ADDR_EN_MAIN, {d[7], cur[6], d[5:0]});
   endtask
   task automatic set_src(input int i, input logic s);
      @(posedge mclk);
      case (i)
         0: ext0_pin_n <= !s;
         1: timer0_req <= s;
         2: ext1_pin_n <= !s;
         3: timer1_req <= s;
         4: uart0_req <= s;
         5: timer2_req <= s;
         6: spi_req <= s;
         7: i2c_req <= s;
         8: conv_done <= s;
         9: module_match_evt <= {5'h00, s};
         default: uart1_req <= s;
      endcase
      conv_flag_clr <= !s && i == 8;
      array_flag_clr <= {7'h00, !s && i == 9};
      @(posedge mclk);
      conv_done <= 1'b0;
      conv_flag_clr <= 1'b0;
      module_match_evt <= 6'h00;
      array_flag_clr <= 8'h00;
   endtask

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   initial begin
      repeat (20000) @(posedge mclk);
      errors++;
      summarize();
   end

   // ********************************************************************
   // Test sequence
   // ********************************************************************
   initial begin
      {reset_n, sfr_wr, sfr_rd, ext0_edge_mode, ext1_edge_mode, conv_done, conv_flag_clr, core_on} = '0;
      {timer0_req, timer1_req, timer2_req, uart0_req, uart1_req, spi_req, i2c_req} = '0;
      {ext0_pin_n, ext1_pin_n} = 2'b11;
      {sfr_addr, sfr_wdata, array_flag_clr, module_match_evt, counter_wrap_evt, ack_dly} = '0;
      repeat (20) @(posedge mclk);
      reset_n <= 1'b1;
      wr(8'h55, 8'hff);
      rd(8'h55, v);
      check(v, 8'h00);
      for (int k = 0; k < 4; k++) begin
         rd(RADDR[k], v);
         check(v, 8'h00);
         if (k == 1) en_main(8'hbf); else wr(RADDR[k], k == 3 ? 8'hff : 8'hf2);
         rd(RADDR[k], v);
         check(v, RMASK[k]);
         if (k == 1) en_main(8'h00); else wr(RADDR[k], 8'h00);
      end
      for (int i = 0; i < 11; i++) begin
         set_src(i, 1'b1);
         if (i >= 6) wr(IRQB_ADDR_EN_EXTRA, EMASK[i]); else en_main(EMASK[i]);
         tick(8);
         check(irq_req, 1'b0);
         en_main(i >= 6 ? 8'h80 : 8'h80 | EMASK[i]);
         tick(3);
         check({irq_req, irq_src}, {1'b1, 4'(i)});
         check(irq_vector, IRQB_VEC_TABLE[i]);
         check({converter_done_flag, ext1_pending, ext0_pending}, {i == 8, i == 2, i == 0});
         en_main(8'h00);
         wr(IRQB_ADDR_EN_EXTRA, 8'h00);
         set_src(i, 1'b0);
         tick(8);
      end
      for (int b = 0; b < 8; b++) begin
         @(posedge mclk);
         if (b < 6) module_match_evt <= 6'(1 << b); else counter_wrap_evt <= 2'(1 << (b - 6));
         @(posedge mclk);
         module_match_evt <= 6'h00;
         counter_wrap_evt <= 2'b00;
         tick(3);
         check({counter1_wrap_flag, counter0_wrap_flag, module_match_flags, array_irq}, {8'(1 << b), 1'b1});
         @(posedge mclk);
         array_flag_clr <= 8'(1 << b);
         @(posedge mclk);
         array_flag_clr <= 8'h00;
         tick(3);
         check(array_irq, 1'b0);
      end
      set_src(1, 1'b1);
      set_src(10, 1'b1);
      wr(IRQB_ADDR_EN_EXTRA, 8'h10);
      en_main(8'h82);
      wr(IRQB_ADDR_LVL_EXTRA, 8'h10);
      tick(3);
      check({irq_high, irq_src}, {1'b1, 4'd10});
      wr(IRQB_ADDR_LVL_EXTRA, 8'h00);
      wr(IRQB_ADDR_LVL_MAIN, 8'h02);
      tick(3);
      check({irq_high, irq_src}, {1'b1, 4'd1});
      wr(IRQB_ADDR_LVL_MAIN, 8'h00);
      set_src(10, 1'b0);
      @(posedge mclk);
      ack_dly <= 4'h2;
      core_on <= 1'b1;
      tick(12);
      check(irq_req, 1'b0);
      wr(IRQB_ADDR_LVL_EXTRA, 8'h10);
      set_src(10, 1'b1);
      hit = 1'b0;
      repeat (12) begin
         @(posedge mclk);
         if (irq_req === 1'b1 && irq_high === 1'b1) hit = 1'b1;
      end
      check(hit, 1'b1);
      @(posedge mclk);
      core_on <= 1'b0;
      set_src(1, 1'b0);
      set_src(10, 1'b0);
      tick(100);
      @(posedge mclk);
      reset_n <= 1'b0;
      tick(3);
      @(posedge mclk);
      reset_n <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         rd(RADDR[k], v);
         check(v, 8'h00);
      end
      for (int m = 0; m < 2; m++) begin
         @(posedge mclk);
         ext0_edge_mode <= m[0];
         ack_dly <= m[0] ? 4'h0 : 4'h3;
         core_on <= 1'b1;
         en_main(8'h81);
         set_src(0, 1'b1);
         tick(16);
         check(ext0_pending, !m[0]);
         @(posedge mclk);
         core_on <= 1'b0;
         set_src(0, 1'b0);
         tick(60);
      end
      summarize();
   end
endmodule
